// *** hw/ccm_regs.sv ***
// Function
// - Reading offset 0x7C returns the operation control byte.
// - Reading offset 0x7D returns the system status byte.
// - Reading offset 0x7E returns the fault byte.
// - Bit 7 read-write; one forces data-line port detection on the charger.
// - Bit 6 read-write; one doubles safety timeout during power limit or thermal.
// - Bit 1 read-write; enables interrupt on nonzero charge fault code.
// - Bit 0 read-write; enables interrupt on battery overvoltage fault flag.
// - Control bits 3 and 2 are read-only, reading 1 and 0.
// - Control bit 4 is read-only and resets to 0.
// - Status bits 7:6 encode input source: unknown, USB, adapter, on-the-go.
// - Status bits 5:4 encode phase: idle, precharge, fast, done.
// - Status bits 3,2,1: power limiting, power good, thermal regulation.
// - Status bit 0 is one while minimum system voltage regulation is active.
// - Fault bit 7 is one after watchdog expiry.
// - Fault bit 6 is one when boost cannot start.
// - Fault bits 5:4 encode normal, input, thermal shutdown, timer expiry.
// - Fault bits 2:0 report thermistor faults; bits 1:0 are held at zero and always read 0.
//
// Register access over Wishbone was left to the implementer.
`default_nettype none
module ccm_regs
  import ccm_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire ccm_status_s chg_status_in,
  input  wire ccm_fault_s  chg_fault_in,
  input  wire logic        batt_switch_off_in,
  output logic             port_detect_force_out,
  output logic             safety_timer_slowdown_out,
  output logic             irq_out
);

  logic        port_detect_force_r;
  logic        safety_timer_slowdown_en_r;
  logic        charge_fault_irq_en_r;
  logic        battery_fault_irq_en_r;
  logic        battery_switch_off_r;
  ccm_status_s status_r;
  ccm_fault_s  fault_r;
  logic [1:0]  ev_stat_r;
  logic [1:0]  ev_mask_r;
  logic        cf_present;
  logic        bf_present;
  logic [1:0]  ev_set;
  logic        req;
  logic        wr_lo;
  logic [7:0]  opctrl;
  logic [31:0] rd_nxt;

  assign req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_lo = req && wb_we_in && wb_sel_in[0];

  always_comb begin
    opctrl                = 8'h00;
    opctrl[CCM_BIT_PDF]   = port_detect_force_r;
    opctrl[CCM_BIT_TMR2X] = safety_timer_slowdown_en_r;
    opctrl[CCM_BIT_BSW]   = battery_switch_off_r;
    opctrl[CCM_BIT_AVP]   = CCM_RST_AVP;
    opctrl[CCM_BIT_RSV3]  = CCM_RST_RSV3;
    opctrl[CCM_BIT_RSV2]  = CCM_RST_RSV2;
    opctrl[CCM_BIT_CFIE]  = charge_fault_irq_en_r;
    opctrl[CCM_BIT_BFIE]  = battery_fault_irq_en_r;
  end

  // Writable control bits; read-only ones have no write path
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_detect_force_r        <= CCM_RST_PDF;
      safety_timer_slowdown_en_r <= CCM_RST_TMR2X;
      charge_fault_irq_en_r      <= CCM_RST_CFIE;
      battery_fault_irq_en_r     <= CCM_RST_BFIE;
    end else if (wr_lo && wb_adr_in == CCM_OFF_OPCTRL) begin
      port_detect_force_r        <= wb_dat_in[CCM_BIT_PDF];
      safety_timer_slowdown_en_r <= wb_dat_in[CCM_BIT_TMR2X];
      charge_fault_irq_en_r      <= wb_dat_in[CCM_BIT_CFIE];
      battery_fault_irq_en_r     <= wb_dat_in[CCM_BIT_BFIE];
    end
  end

  // Charger mirror; bus writes never reach these
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_r             <= '0;
      fault_r              <= '0;
      battery_switch_off_r <= CCM_RST_BSW;
    end else begin
      status_r             <= chg_status_in;
      fault_r              <= chg_fault_in;
      fault_r.thermistor_fault_code[1:0] <= 2'h0;
      battery_switch_off_r <= batt_switch_off_in;
    end
  end

  assign cf_present = fault_r.charge_fault_code != CCM_CF_NORMAL;
  assign bf_present = fault_r.battery_fault_flag;
  assign ev_set     = {cf_present && charge_fault_irq_en_r,
                       bf_present && battery_fault_irq_en_r};

  // Sticky events, set wins over write-one-to-clear
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ev_stat_r <= CCM_EV_RST;
    end else if (wr_lo && wb_adr_in == CCM_OFF_EVSTAT) begin
      ev_stat_r <= (ev_stat_r & ~wb_dat_in[1:0]) | ev_set;
    end else begin
      ev_stat_r <= ev_stat_r | ev_set;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ev_mask_r <= CCM_EV_RST;
    end else if (wr_lo && wb_adr_in == CCM_OFF_EVMASK) begin
      ev_mask_r <= wb_dat_in[1:0];
    end
  end

  // Level interrupt: only while a fault is present and enabled
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ev_stat_r & ev_mask_r & ev_set);
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_in)
      CCM_OFF_OPCTRL: rd_nxt[7:0] = opctrl;
      CCM_OFF_STATUS: rd_nxt[7:0] = status_r;
      CCM_OFF_FAULT:  rd_nxt[7:0] = fault_r;
      CCM_OFF_EVSTAT: rd_nxt[1:0] = ev_stat_r;
      CCM_OFF_EVMASK: rd_nxt[1:0] = ev_mask_r;
      default:        rd_nxt = 32'h0000_0000;
    endcase
  end

  // Single-cycle ack; unmapped addresses read zero and ignore writes
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        wb_dat_out <= rd_nxt;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_detect_force_out     <= CCM_RST_PDF;
      safety_timer_slowdown_out <= CCM_RST_TMR2X;
    end else begin
      port_detect_force_out     <= port_detect_force_r;
      safety_timer_slowdown_out <= safety_timer_slowdown_en_r;
    end
  end

  // Bus-view helpers for the checks below
  logic        rd_ctl;
  logic        rd_sts;
  logic        rd_flt;
  logic        rd_map;
  logic        wr_ctl;
  logic        wr_evs;
  logic        wr_ro;
  logic [5:0]  cfg_bits;

  assign rd_ctl   = req && !wb_we_in && wb_adr_in == CCM_OFF_OPCTRL;
  assign rd_sts   = req && !wb_we_in && wb_adr_in == CCM_OFF_STATUS;
  assign rd_flt   = req && !wb_we_in && wb_adr_in == CCM_OFF_FAULT;
  assign rd_map   = wb_adr_in inside {CCM_OFF_OPCTRL, CCM_OFF_STATUS, CCM_OFF_FAULT,
                                      CCM_OFF_EVSTAT, CCM_OFF_EVMASK};
  assign wr_ctl   = wr_lo && wb_adr_in == CCM_OFF_OPCTRL;
  assign wr_evs   = wr_lo && wb_adr_in == CCM_OFF_EVSTAT;
  assign wr_ro    = req && wb_we_in && wb_adr_in inside {CCM_OFF_STATUS, CCM_OFF_FAULT, CCM_OFF_STRAP};
  assign cfg_bits = {port_detect_force_r, safety_timer_slowdown_en_r, charge_fault_irq_en_r,
                     battery_fault_irq_en_r, ev_mask_r};

  a_ack_one_cycle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wb_ack_out |=> !wb_ack_out) else $error("ack held two cycles");
  a_opctrl_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    req && !wb_we_in && wb_adr_in == CCM_OFF_OPCTRL |=> wb_dat_out[7:0] == $past(opctrl))
    else $error("control read wrong");
  a_status_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    req && !wb_we_in && wb_adr_in == CCM_OFF_STATUS |=> wb_dat_out[7:0] == $past(chg_status_in, 2))
    else $error("status read wrong");
  a_fault_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    req && !wb_we_in && wb_adr_in == CCM_OFF_FAULT |=> wb_dat_out[7:2] == $past(chg_fault_in[7:2], 2))
    else $error("fault read wrong");
  a_pdf_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_lo && wb_adr_in == CCM_OFF_OPCTRL |=> ##1 port_detect_force_out == $past(wb_dat_in[7], 2))
    else $error("port detect not written");
  a_tmr_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_lo && wb_adr_in == CCM_OFF_OPCTRL |=> safety_timer_slowdown_en_r == $past(wb_dat_in[6]))
    else $error("slowdown not written");
  a_cf_enable: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_lo && wb_adr_in == CCM_OFF_OPCTRL |=> charge_fault_irq_en_r == $past(wb_dat_in[1]))
    else $error("charge enable not written");
  a_bf_enable: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_lo && wb_adr_in == CCM_OFF_OPCTRL |=> battery_fault_irq_en_r == $past(wb_dat_in[0]))
    else $error("battery enable not written");
  a_rsv_bits: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_ctl |=> wb_dat_out[3:2] == {CCM_RST_RSV3, CCM_RST_RSV2}) else $error("reserved bits wrong");
  a_avp_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_ctl |=> !wb_dat_out[CCM_BIT_AVP]) else $error("bit 4 not zero");
  a_status_mirror: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ##1 status_r == $past(chg_status_in)) else $error("status not mirrored");
  a_thermistor_low: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    fault_r.thermistor_fault_code[1:0] == 2'h0) else $error("thermistor low bits set");
  a_fault_mirror: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ##1 fault_r[7:2] == $past(chg_fault_in[7:2])) else $error("fault not mirrored");
  a_irq_cause: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    irq_out |-> $past((cf_present && charge_fault_irq_en_r) || (bf_present && battery_fault_irq_en_r)))
    else $error("irq without enabled fault");
  a_sticky_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    ev_set[CCM_EV_CF] |=> ev_stat_r[CCM_EV_CF]) else $error("event lost");

  // Field placement as seen on the bus
  a_src_field: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_sts |=> wb_dat_out[7:6] == $past(status_r.input_source_type))
    else $error("source type misplaced");
  a_phase_field: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_sts |=> wb_dat_out[5:4] == $past(status_r.charge_phase))
    else $error("charge phase misplaced");
  a_limit_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_sts |=> wb_dat_out[3] == $past(status_r.power_limit_flag))
    else $error("power limit flag misplaced");
  a_good_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_sts |=> wb_dat_out[2] == $past(status_r.input_good_flag))
    else $error("power good flag misplaced");
  a_therm_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_sts |=> wb_dat_out[1] == $past(status_r.thermal_reg_flag))
    else $error("thermal flag misplaced");
  a_minsys_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_sts |=> wb_dat_out[0] == $past(status_r.min_sys_reg_flag))
    else $error("min system flag misplaced");
  a_wdog_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_flt |=> wb_dat_out[7] == $past(fault_r.wdog_fault_flag))
    else $error("watchdog flag misplaced");
  a_boost_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_flt |=> wb_dat_out[6] == $past(fault_r.boost_fault_flag))
    else $error("boost flag misplaced");
  a_cf_code: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_flt |=> wb_dat_out[5:4] == $past(fault_r.charge_fault_code))
    else $error("charge fault code misplaced");
  a_bf_flag: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_flt |=> wb_dat_out[3] == $past(fault_r.battery_fault_flag))
    else $error("battery fault flag misplaced");
  a_ntc_high: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_flt |=> wb_dat_out[2] == $past(fault_r.thermistor_fault_code[2]))
    else $error("thermistor bit 2 misplaced");
  a_ntc_read: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_flt |=> wb_dat_out[1:0] == 2'h0)
    else $error("thermistor low bits read set");

  // Bus protocol and refused accesses
  a_ack_answer: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    req |=> wb_ack_out)
    else $error("request not acknowledged");
  a_ack_cause: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !req |=> !wb_ack_out)
    else $error("ack without request");
  a_rdata_hold: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !(req && !wb_we_in) |=> $stable(wb_dat_out))
    else $error("read data moved without read");
  a_upper_zero: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    rd_ctl || rd_sts || rd_flt |=> wb_dat_out[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    req && !wb_we_in && !rd_map |=> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ro_write: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_ro |=> $stable(cfg_bits))
    else $error("read-only write landed");
  a_sel_gate: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    req && wb_we_in && !wb_sel_in[0] |=> $stable(cfg_bits))
    else $error("write without lane landed");
  a_read_only: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    req && !wb_we_in |=> $stable(cfg_bits))
    else $error("read changed settings");
  a_bsw_mirror: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ##1 battery_switch_off_r == $past(batt_switch_off_in))
    else $error("switch bit not mirrored");
  a_ctl_bsw: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_ctl |=> battery_switch_off_r == $past(batt_switch_off_in))
    else $error("switch bit written by bus");

  // Events and interrupt
  a_mask_write: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_lo && wb_adr_in == CCM_OFF_EVMASK |=> ev_mask_r == $past(wb_dat_in[1:0]))
    else $error("mask not written");
  a_bf_clear: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_evs && wb_dat_in[CCM_EV_BF] && !ev_set[CCM_EV_BF] |=> !ev_stat_r[CCM_EV_BF])
    else $error("battery event not cleared");
  a_cf_clear: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_evs && wb_dat_in[CCM_EV_CF] && !ev_set[CCM_EV_CF] |=> !ev_stat_r[CCM_EV_CF])
    else $error("charge event not cleared");
  a_set_wins: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    wr_evs && ev_set[CCM_EV_CF] |=> ev_stat_r[CCM_EV_CF])
    else $error("clear beat a live event");
  a_bf_sticky: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ev_set[CCM_EV_BF] |=> ev_stat_r[CCM_EV_BF])
    else $error("battery event lost");
  a_ev_hold: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ev_stat_r[CCM_EV_BF] && !wr_evs |=> ev_stat_r[CCM_EV_BF])
    else $error("event dropped without clear");
  a_irq_masked: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ev_mask_r == 2'h0 |=> !irq_out)
    else $error("irq while fully masked");
  a_irq_no_fault: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !cf_present && !bf_present |=> !irq_out)
    else $error("irq with no fault");
  a_cf_irq_on: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ev_stat_r[CCM_EV_CF] && ev_mask_r[CCM_EV_CF] && cf_present && charge_fault_irq_en_r |=> irq_out)
    else $error("charge fault irq missing");
  a_bf_irq_on: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ev_stat_r[CCM_EV_BF] && ev_mask_r[CCM_EV_BF] && bf_present && battery_fault_irq_en_r |=> irq_out)
    else $error("battery fault irq missing");
  a_cf_irq_off: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !charge_fault_irq_en_r && !bf_present |=> !irq_out)
    else $error("irq with charge enable off");
  a_bf_irq_off: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    !battery_fault_irq_en_r && !cf_present |=> !irq_out)
    else $error("irq with battery enable off");

  // Control outputs
  a_pdf_follow: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ##1 port_detect_force_out == $past(port_detect_force_r))
    else $error("port detect output stale");
  a_slow_follow: assert property (
    @(posedge core_clk_in) disable iff (!nrst_in)
    ##1 safety_timer_slowdown_out == $past(safety_timer_slowdown_en_r))
    else $error("slowdown output stale");

  c_ctrl_write: cover property (@(posedge core_clk_in) wr_lo && wb_adr_in == CCM_OFF_OPCTRL);
  c_fault_read: cover property (@(posedge core_clk_in) req && !wb_we_in && wb_adr_in == CCM_OFF_FAULT);
  c_irq_rise:   cover property (@(posedge core_clk_in) $rose(irq_out));
  c_clear_set:  cover property (@(posedge core_clk_in) wr_lo && wb_adr_in == CCM_OFF_EVSTAT && |ev_set);

endmodule
`default_nettype wire

// *** hw/ccm_pkg.sv ***
`default_nettype none
package ccm_pkg;
  localparam logic [7:0] CCM_OFF_OPCTRL  = 8'h7C;
  localparam logic [7:0] CCM_OFF_STATUS  = 8'h7D;
  localparam logic [7:0] CCM_OFF_FAULT   = 8'h7E;
  localparam logic [7:0] CCM_OFF_EVSTAT  = 8'h80;
  localparam logic [7:0] CCM_OFF_EVMASK  = 8'h84;
  localparam logic [7:0] CCM_OFF_STRAP   = 8'h88;

  localparam int CCM_BIT_PDF   = 7;
  localparam int CCM_BIT_TMR2X = 6;
  localparam int CCM_BIT_BSW   = 5;
  localparam int CCM_BIT_AVP   = 4;
  localparam int CCM_BIT_RSV3  = 3;
  localparam int CCM_BIT_RSV2  = 2;
  localparam int CCM_BIT_CFIE  = 1;
  localparam int CCM_BIT_BFIE  = 0;

  localparam logic CCM_RST_PDF   = 1'b0;
  localparam logic CCM_RST_TMR2X = 1'b1;
  localparam logic CCM_RST_BSW   = 1'b0;
  localparam logic CCM_RST_AVP   = 1'b0;
  localparam logic CCM_RST_RSV3  = 1'b1;
  localparam logic CCM_RST_RSV2  = 1'b0;
  localparam logic CCM_RST_CFIE  = 1'b1;
  localparam logic CCM_RST_BFIE  = 1'b1;

  localparam logic [1:0] CCM_SRC_UNKNOWN = 2'h0;
  localparam logic [1:0] CCM_SRC_USB     = 2'h1;
  localparam logic [1:0] CCM_SRC_ADAPTER = 2'h2;
  localparam logic [1:0] CCM_SRC_OTG     = 2'h3;
  localparam logic [1:0] CCM_PH_IDLE     = 2'h0;
  localparam logic [1:0] CCM_PH_PRE      = 2'h1;
  localparam logic [1:0] CCM_PH_FAST     = 2'h2;
  localparam logic [1:0] CCM_PH_DONE     = 2'h3;
  localparam logic [1:0] CCM_CF_NORMAL   = 2'h0;
  localparam logic [1:0] CCM_CF_INPUT    = 2'h1;
  localparam logic [1:0] CCM_CF_THERMAL  = 2'h2;
  localparam logic [1:0] CCM_CF_TIMER    = 2'h3;

  localparam int CCM_EV_CF = 1;
  localparam int CCM_EV_BF = 0;
  localparam logic [1:0] CCM_EV_RST = 2'h0;

  typedef struct packed {
    logic [1:0] input_source_type;
    logic [1:0] charge_phase;
    logic       power_limit_flag;
    logic       input_good_flag;
    logic       thermal_reg_flag;
    logic       min_sys_reg_flag;
  } ccm_status_s;

  typedef struct packed {
    logic       wdog_fault_flag;
    logic       boost_fault_flag;
    logic [1:0] charge_fault_code;
    logic       battery_fault_flag;
    logic [2:0] thermistor_fault_code;
  } ccm_fault_s;
endpackage
`default_nettype wire

// *** verification/ccm_chg_model.sv ***
`default_nettype none
module ccm_chg_model
  import ccm_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        port_detect_force_in,
  input  wire ccm_status_s status_set_in,
  input  wire ccm_fault_s  fault_set_in,
  input  wire logic        batt_off_set_in,
  output var ccm_status_s  chg_status_out,
  output var ccm_fault_s   chg_fault_out,
  output logic             batt_switch_off_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Forced port detection leaves the source type undetermined
  always_ff @(posedge core_clk_in) begin
    chg_status_out <= status_set_in;
    if (port_detect_force_in) begin
      chg_status_out.input_source_type <= CCM_SRC_UNKNOWN;
    end
    chg_fault_out <= fault_set_in;
    batt_switch_off_out <= batt_off_set_in;
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none
module testbench
  import ccm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  ccm_status_s st;
  ccm_status_s st_set = 8'h00;
  ccm_fault_s  ft;
  ccm_fault_s  ft_set = 8'h00;
  logic        bsw;
  logic        bsw_set = 1'b0;
  logic        pdf;
  logic        slow;
  logic        irq;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;

  ccm_regs i_ccm_regs (.core_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .chg_status_in(st), .chg_fault_in(ft), .batt_switch_off_in(bsw),
    .port_detect_force_out(pdf), .safety_timer_slowdown_out(slow), .irq_out(irq));
  ccm_chg_model i_ccm_chg_model (.core_clk_in(clk), .port_detect_force_in(pdf),
    .status_set_in(st_set), .fault_set_in(ft_set), .batt_off_set_in(bsw_set),
    .chg_status_out(st), .chg_fault_out(ft), .batt_switch_off_out(bsw));

  always #20 clk = ~clk;

  task automatic results;
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      results;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; returns one edge after the release
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, 4'hF, q);
    chk(q, {24'h0, exp});
  endtask

  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  task automatic t_reset;
    rdc(CCM_OFF_OPCTRL, 8'h4B);
    chk(32'(pdf), 32'h0);
    chk(32'(slow), 32'h1);
  endtask

  task automatic t_ctrl;
    bsw_set <= 1'b1;
    wr(CCM_OFF_OPCTRL, 8'hFF, 4'hF);
    settle;
    rdc(CCM_OFF_OPCTRL, 8'hEB);
    chk(32'(pdf), 32'h1);
    wr(CCM_OFF_OPCTRL, 8'h00, 4'hE);
    rdc(CCM_OFF_OPCTRL, 8'hEB);
    bsw_set <= 1'b0;
    wr(CCM_OFF_OPCTRL, 8'h00, 4'hF);
    settle;
    rdc(CCM_OFF_OPCTRL, 8'h08);
    chk(32'(slow), 32'h0);
    chk(32'(pdf), 32'h0);
  endtask

  task automatic t_status;
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      e = {i[1:0], 2'(3 - i), 4'(1 << i)};
      st_set <= e;
      settle;
      rdc(CCM_OFF_STATUS, e);
    end
    wr(CCM_OFF_STATUS, 8'h00, 4'hF);
    rdc(CCM_OFF_STATUS, 8'hC8);
  endtask

  task automatic t_fault;
    logic [7:0] fv [4] = '{8'h8F, 8'h5B, 8'hAF, 8'h77};
    for (int i = 0; i < 4; i++) begin
      ft_set <= fv[i];
      settle;
      rdc(CCM_OFF_FAULT, fv[i] & 8'hFC);
    end
    wr(CCM_OFF_FAULT, 8'h00, 4'hF);
    rdc(CCM_OFF_FAULT, 8'h74);
  endtask

  task automatic t_irq;
    ft_set <= 8'h00;
    wr(CCM_OFF_EVMASK, 8'h03, 4'hF);
    settle;
    rdc(CCM_OFF_EVSTAT, 8'h00);
    wr(CCM_OFF_OPCTRL, 8'h03, 4'hF);
    ft_set <= 8'h08;
    settle;
    chk(32'(irq), 32'h1);
    rdc(CCM_OFF_EVSTAT, 8'h01);
    wr(CCM_OFF_EVMASK, 8'h00, 4'hF);
    settle;
    chk(32'(irq), 32'h0);
    wr(CCM_OFF_EVMASK, 8'h03, 4'hF);
    ft_set <= 8'h20;
    settle;
    chk(32'(irq), 32'h1);
    rdc(CCM_OFF_EVSTAT, 8'h03);
    wr(CCM_OFF_EVSTAT, 8'h03, 4'hF);
    rdc(CCM_OFF_EVSTAT, 8'h02);
    ft_set <= 8'h00;
    settle;
    wr(CCM_OFF_EVSTAT, 8'h03, 4'hF);
    rdc(CCM_OFF_EVSTAT, 8'h00);
    chk(32'(irq), 32'h0);
    rdc(8'h90, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_ctrl;
    t_status;
    t_fault;
    t_irq;
    results;
  end
endmodule
`default_nettype wire
